// ==== bus_condition_detect.v ====
module bus_condition_detect (
   input wire clk,
   input wire rst,
   input wire scl_in,
   input wire sda_in,
   output reg scl_rise,
   output reg scl_fall,
   output reg start_det,
   output reg stop_det,
   output reg sda_q
);

   reg scl_q;
   reg scl_d;
   reg sda_d;

   // ----------------------------------------
   // Line history
   // ----------------------------------------
   // Two stages of history; pins are already synchronous to clk
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         scl_d <= 1'b1;
         sda_q <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_q <= scl_in;
         scl_d <= scl_q;
         sda_q <= sda_in;
         sda_d <= sda_q;
      end
   end

   // ----------------------------------------
   // Edges and bus conditions
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_rise <= 1'b0;
         scl_fall <= 1'b0;
         start_det <= 1'b0;
         stop_det <= 1'b0;
      end else begin
         scl_rise <= scl_q & ~scl_d;
         scl_fall <= ~scl_q & scl_d;
         // Data moving while clock stays high marks start or stop
         start_det <= scl_q & scl_d & sda_d & ~sda_q;
         stop_det <= scl_q & scl_d & ~sda_d & sda_q;
      end
   end

endmodule // bus_condition_detect

// ==== i2c_ctrl_model.sv ====
module i2c_ctrl_model #(
   parameter int P = 8
) (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clock stands high between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // data moves only with scl low
   task automatic bit_x(input logic b, output logic r);
      sda_low <= !b;
      tick(P);
      scl <= 1'b1;
      tick(P);
      r = sda_line;
      scl <= 1'b0;
      tick(1);
   endtask
   task automatic start_c;
      sda_low <= 1'b0;
      tick(P);
      scl <= 1'b1;
      tick(P);
      sda_low <= 1'b1;
      tick(P);
      scl <= 1'b0;
      tick(1);
   endtask
   task automatic stop_c;
      sda_low <= 1'b1;
      tick(P);
      scl <= 1'b1;
      tick(P);
      sda_low <= 1'b0;
      tick(P);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack_n);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, ack_n);
   endtask
   // last byte of a read ends with a nack
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(last, r);
   endtask
endmodule // i2c_ctrl_model

// ==== redriver_bank_props.sv ====
module redriver_bank_props (
   input wire clk,
   input wire rst,
   input wire scl_in,
   input wire sda_out,
   input wire sda_oe_n,
   input wire supply_high_valid,
   input wire supply_low_valid,
   input wire repeater_enable,
   input wire soft_reset_pulse,
   input wire auto_speed,
   input wire low_full_speed,
   input wire [7:0] link_speed_role_opmode,
   input wire [7:0] embedded_rx_tuning,
   input wire [7:0] embedded_tx_tuning,
   input wire [7:0] legacy_rx_tuning,
   input wire [7:0] legacy_tx_edge_swing,
   input wire [7:0] legacy_hs_termination,
   input wire [7:0] remote_access_key
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire pwr_ok = supply_high_valid && supply_low_valid;
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence s_defaults;
      embedded_rx_tuning == 8'h20 && embedded_tx_tuning == 8'h10 && legacy_rx_tuning == 8'h50
      && legacy_tx_edge_swing == 8'h62 && legacy_hs_termination == 8'h02
      && remote_access_key == 8'h00 && link_speed_role_opmode == 8'h00;
   endsequence
   // Four cycles leave room for the enable flop lag
   sequence s_unpowered;
      !pwr_ok [*4];
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_open_drain_low: assert property (sda_out == 1'b0)
      else $error("sda drive value not zero");
   a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("sda drive changed while scl high");
   a_enable_off: assert property (!pwr_ok |=> !repeater_enable)
      else $error("enabled without both supplies");
   a_enable_on: assert property (pwr_ok |=> repeater_enable)
      else $error("not enabled with both supplies");
   a_unpowered_idle: assert property (s_unpowered |-> sda_oe_n)
      else $error("sda driven while unpowered");
   a_unpowered_defaults: assert property (s_unpowered |-> s_defaults)
      else $error("registers not at defaults while unpowered");
   a_soft_pulse_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("soft reset pulse longer than one cycle");
   a_soft_reset_defaults: assert property (soft_reset_pulse |=> s_defaults)
      else $error("registers not restored after soft reset");
   a_speed_auto: assert property (link_speed_role_opmode[7:6] == 2'b00
      |=> auto_speed && !low_full_speed)
      else $error("auto speed decode wrong");
   a_speed_low_full: assert property (link_speed_role_opmode[7:6] == 2'b01
      |=> low_full_speed && !auto_speed)
      else $error("low full speed decode wrong");
   a_speed_reserved: assert property (link_speed_role_opmode[7]
      |=> !auto_speed && !low_full_speed)
      else $error("reserved speed decode wrong");
endmodule // redriver_bank_props

bind redriver_config_register_bank redriver_bank_props u_redriver_bank_props (.clk(clk),
   .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .supply_high_valid(supply_high_valid), .supply_low_valid(supply_low_valid),
   .repeater_enable(repeater_enable), .soft_reset_pulse(soft_reset_pulse),
   .auto_speed(auto_speed), .low_full_speed(low_full_speed),
   .link_speed_role_opmode(link_speed_role_opmode), .embedded_rx_tuning(embedded_rx_tuning),
   .embedded_tx_tuning(embedded_tx_tuning), .legacy_rx_tuning(legacy_rx_tuning),
   .legacy_tx_edge_swing(legacy_tx_edge_swing), .legacy_hs_termination(legacy_hs_termination),
   .remote_access_key(remote_access_key));

// ==== redriver_config_register_bank.v ====
// Function
// - All registers reachable over the serial target port, single or sequential.
// - After power-on the repeater runs from default register values alone.
// - Nothing works until both supplies are valid; no supply ordering imposed.
// - Read-write fields read back the last value written.
// - Read-only fields report live state; writes never change them.
// - Write-only reads are meaningless and trigger no action.
// - Read-as-zero fields always read zero; writes change nothing.
// - Write-one-to-set bits: one sets, zero ignored, bit stays readable.
// - Each register loads its listed default at power-on.
// - Software reset bit restores read-write registers, self-clears, reads zero.
// - Speed field 00 selects auto negotiation, 01 low/full speed only.
// - Undefined addresses are acknowledged; reads give ff, writes dropped.
// - Register address auto-increments per byte, wrapping ff to 00.
`include "redriver_consts.vh"

module redriver_config_register_bank #(
   // Identification values are arbitrary
   parameter [7:0] REVISION_CODE = 8'h1c,
   parameter [7:0] PART_CODE_LOW = 8'h7e,
   parameter [7:0] PART_CODE_MID = 8'h45,
   parameter [7:0] PART_CODE_HIGH = 8'h03
) (
   input wire clk,
   input wire rst,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe_n,
   input wire [1:0] target_addr_sel,
   input wire supply_high_valid,
   input wire supply_low_valid,
   input wire [1:0] speed_of_operation,
   input wire [1:0] repeater_status,
   input wire [2:0] link_status,
   output wire repeater_enable,
   output wire soft_reset_pulse,
   output wire auto_speed,
   output wire low_full_speed,
   output wire [7:0] link_speed_role_opmode,
   output wire forced_single_ended_one,
   output wire [7:0] embedded_rx_tuning,
   output wire [7:0] embedded_tx_tuning,
   output wire [7:0] legacy_rx_tuning,
   output wire [7:0] legacy_tx_emphasis,
   output wire [7:0] legacy_tx_edge_swing,
   output wire [7:0] legacy_hs_termination,
   output wire [7:0] legacy_disconnect_level,
   output wire [7:0] remote_access_key,
   output wire control_message_gate_enable
);

   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_RX = 3'd1;
   localparam [2:0] ST_ACK = 3'd2;
   localparam [2:0] ST_TX = 3'd3;
   localparam [2:0] ST_TX_ACK = 3'd4;
   localparam [2:0] ST_TX_LOAD = 3'd5;

   localparam [1:0] K_DEV = 2'd0;
   localparam [1:0] K_REG = 2'd1;
   localparam [1:0] K_DATA = 2'd2;

   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   wire sda_q;

   reg [2:0] state_r;
   reg [1:0] kind_r;
   reg [3:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg [7:0] ptr_r;
   reg read_mode_r;
   reg sda_oe_n_r;
   reg sda_out_r;
   reg wr_fire_r;
   reg [7:0] wr_addr_r;
   reg [7:0] wr_data_r;
   reg powered_r;
   reg soft_reset_r;
   reg auto_speed_r;
   reg low_full_speed_r;
   reg [7:0] speed_state_r;
   reg [7:0] conn_state_r;
   reg [7:0] rd_data;

   wire [6:0] own_addr;
   wire [7:0] slot_val [0:`SLOT_COUNT-1];

   assign own_addr = {`TARGET_ADDR_HIGH, target_addr_sel, `TARGET_ADDR_LOW};

   // ----------------------------------------
   // Per-slot tables
   // ----------------------------------------
   // power-on values
   function [7:0] slot_reset;
      input integer idx;
      begin
         case (idx)
            4: slot_reset = `RST_EMBEDDED_RX;
            5: slot_reset = `RST_EMBEDDED_TX;
            6: slot_reset = `RST_LEGACY_RX;
            8: slot_reset = `RST_LEGACY_TX_EDGE;
            9: slot_reset = `RST_LEGACY_HS_TERM;
            default: slot_reset = `RST_ZERO;
         endcase
      end
   endfunction

   // Blank bits of a register stay read-as-zero through the mask
   function [7:0] slot_wmask;
      input integer idx;
      begin
         case (idx)
            2, 4, 5, 6, 7, 8, 9, 10, 13: slot_wmask = `WMASK_FULL;
            3, 14: slot_wmask = `WMASK_BIT0;
            default: slot_wmask = `WMASK_NONE;
         endcase
      end
   endfunction

   // No field of this map is write-one-to-set; the path is kept for reuse
   function [7:0] slot_w1s;
      input integer idx;
      begin
         case (idx)
            default: slot_w1s = `W1S_NONE;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Edge and condition detection
   // ----------------------------------------
   bus_condition_detect cond (
      .clk(clk),
      .rst(rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_det(start_det),
      .stop_det(stop_det),
      .sda_q(sda_q)
   );

   // ----------------------------------------
   // Supply gate and status capture
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         powered_r <= 1'b0;
         speed_state_r <= 8'h00;
         conn_state_r <= 8'h00;
         auto_speed_r <= 1'b1;
         low_full_speed_r <= 1'b0;
      end else begin
         powered_r <= supply_high_valid & supply_low_valid;
         speed_state_r <= {4'h0, speed_of_operation, repeater_status};
         conn_state_r <= {5'h00, link_status};
         // speed decode; reserved codes select neither
         auto_speed_r <= slot_val[2][`SPEED_MSB:`SPEED_LSB] == `SPEED_AUTO;
         low_full_speed_r <= slot_val[2][`SPEED_MSB:`SPEED_LSB] == `SPEED_LOW_FULL;
      end
   end

   // ----------------------------------------
   // Software reset trigger
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         soft_reset_r <= 1'b0;
      end else begin
         soft_reset_r <= wr_fire_r & (wr_addr_r == `OFS_SOFTWARE_RESET) &
            wr_data_r[`SOFT_RESET_BIT];
      end
   end

   // ----------------------------------------
   // Register slots
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `SLOT_COUNT; gi = gi + 1) begin : slot
         reg [7:0] val_r;
         wire [7:0] wmask;
         wire [7:0] w1s;
         wire hit;
         assign wmask = slot_wmask(gi);
         assign w1s = slot_w1s(gi);
         assign hit = wr_fire_r & (wr_addr_r == gi[7:0]);
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               val_r <= slot_reset(gi);
            end else if (!powered_r || soft_reset_r) begin
               val_r <= slot_reset(gi);
            end else if (hit) begin
               val_r <= (val_r & ~wmask) | (wr_data_r & wmask) | (wr_data_r & w1s);
            end
         end
         assign slot_val[gi] = val_r;
      end
   endgenerate

   // ----------------------------------------
   // Read multiplexer
   // ----------------------------------------
   // reads have no side effects
   always @* begin
      rd_data = `UNMAPPED_READ;
      case (ptr_r)
         `OFS_RESERVED_ZERO: rd_data = 8'h00;
         `OFS_SOFTWARE_RESET: rd_data = 8'h00;
         `OFS_LINK_SPEED_ROLE, `OFS_LINK_FORCE, `OFS_EMBEDDED_RX,
         `OFS_EMBEDDED_TX, `OFS_LEGACY_RX, `OFS_LEGACY_TX_EMPH,
         `OFS_LEGACY_TX_EDGE, `OFS_LEGACY_HS_TERM, `OFS_LEGACY_DISC,
         `OFS_REMOTE_KEY, `OFS_CTRL_MSG_GATE: begin
            rd_data = slot_val[ptr_r[3:0]];
         end
         `OFS_RESERVED_RO: rd_data = 8'h00;
         `OFS_SPEED_STATE: rd_data = speed_state_r;
         `OFS_CONN_STATE: rd_data = conn_state_r;
         `OFS_RAZ_FIRST, `OFS_RAZ_LAST: rd_data = 8'h00;
         `OFS_REVISION: rd_data = REVISION_CODE;
         `OFS_PART_LOW: rd_data = PART_CODE_LOW;
         `OFS_PART_MID: rd_data = PART_CODE_MID;
         `OFS_PART_HIGH: rd_data = PART_CODE_HIGH;
         default: rd_data = `UNMAPPED_READ;
      endcase
   end

   // ----------------------------------------
   // Serial target state machine
   // ----------------------------------------
   // SDA only changes after a detected SCL fall, so hold time is a few clocks
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         kind_r <= K_DEV;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         read_mode_r <= 1'b0;
         sda_oe_n_r <= 1'b1;
         sda_out_r <= 1'b0;
         wr_fire_r <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
      end else begin
         wr_fire_r <= 1'b0;
         if (!powered_r) begin
            state_r <= ST_IDLE;
            sda_oe_n_r <= 1'b1;
         end else if (start_det) begin
            state_r <= ST_RX;
            kind_r <= K_DEV;
            bit_cnt_r <= 4'h0;
            sda_oe_n_r <= 1'b1;
         end else if (stop_det) begin
            state_r <= ST_IDLE;
            sda_oe_n_r <= 1'b1;
         end else begin
            case (state_r)
               ST_IDLE: begin
                  sda_oe_n_r <= 1'b1;
               end
               ST_RX: begin
                  if (scl_rise && bit_cnt_r != 4'h8) begin
                     shift_r <= {shift_r[6:0], sda_q};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else if (scl_fall && bit_cnt_r == 4'h8) begin
                     bit_cnt_r <= 4'h0;
                     case (kind_r)
                        K_DEV: begin
                           if (shift_r[7:1] == own_addr) begin
                              read_mode_r <= shift_r[0];
                              sda_oe_n_r <= 1'b0;
                              state_r <= ST_ACK;
                           end else begin
                              state_r <= ST_IDLE;
                           end
                        end
                        K_REG: begin
                           ptr_r <= shift_r;
                           sda_oe_n_r <= 1'b0;
                           state_r <= ST_ACK;
                        end
                        default: begin
                           // unmapped writes dropped in the slots
                           wr_fire_r <= 1'b1;
                           wr_addr_r <= ptr_r;
                           wr_data_r <= shift_r;
                           ptr_r <= ptr_r + 8'h01;
                           sda_oe_n_r <= 1'b0;
                           state_r <= ST_ACK;
                        end
                     endcase
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     if (kind_r == K_DEV && read_mode_r) begin
                        sda_oe_n_r <= rd_data[7];
                        shift_r <= {rd_data[6:0], 1'b0};
                        bit_cnt_r <= 4'h1;
                        state_r <= ST_TX;
                     end else begin
                        sda_oe_n_r <= 1'b1;
                        kind_r <= (kind_r == K_DEV) ? K_REG : K_DATA;
                        bit_cnt_r <= 4'h0;
                        state_r <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_r == 4'h8) begin
                        sda_oe_n_r <= 1'b1;
                        state_r <= ST_TX_ACK;
                     end else begin
                        sda_oe_n_r <= shift_r[7];
                        shift_r <= {shift_r[6:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (scl_rise) begin
                     if (sda_q) begin
                        // Controller refused; wait for stop or restart
                        state_r <= ST_IDLE;
                     end else begin
                        ptr_r <= ptr_r + 8'h01;
                        state_r <= ST_TX_LOAD;
                     end
                  end
               end
               ST_TX_LOAD: begin
                  if (scl_fall) begin
                     sda_oe_n_r <= rd_data[7];
                     shift_r <= {rd_data[6:0], 1'b0};
                     bit_cnt_r <= 4'h1;
                     state_r <= ST_TX;
                  end
               end
               default: begin
                  state_r <= ST_IDLE;
                  sda_oe_n_r <= 1'b1;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // controls run from defaults with no write needed
   assign sda_out = sda_out_r;
   assign sda_oe_n = sda_oe_n_r;
   assign repeater_enable = powered_r;
   assign soft_reset_pulse = soft_reset_r;
   assign auto_speed = auto_speed_r;
   assign low_full_speed = low_full_speed_r;
   assign link_speed_role_opmode = slot_val[2];
   assign forced_single_ended_one = slot_val[3][0];
   assign embedded_rx_tuning = slot_val[4];
   assign embedded_tx_tuning = slot_val[5];
   assign legacy_rx_tuning = slot_val[6];
   assign legacy_tx_emphasis = slot_val[7];
   assign legacy_tx_edge_swing = slot_val[8];
   assign legacy_hs_termination = slot_val[9];
   assign legacy_disconnect_level = slot_val[10];
   assign remote_access_key = slot_val[13];
   assign control_message_gate_enable = slot_val[14][`GATE_ENABLE_BIT];

endmodule // redriver_config_register_bank

// ==== redriver_config_register_bank_tb_top.sv ====
module redriver_config_register_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // Identification values are arbitrary
   localparam logic [7:0] REV = 8'h5b, PLO = 8'h39, PMI = 8'h6a, PHI = 8'h01;
   logic clk, rst, scl, sda_low, sda_line, sda_out, sda_oe_n;
   logic sup_hi, sup_lo, repeater_enable, soft_reset_pulse, auto_speed, low_full_speed;
   logic forced_single_ended_one, control_message_gate_enable;
   logic [1:0] sel, spd, rep;
   logic [2:0] lnk;
   logic [7:0] lsro, erx, etx, lrx, ltxe, ltxs, lterm, ldisc, rkey, dev_w;
   logic [7:0] buf_q [0:31];
   logic [7:0] wexp [0:4] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h3c};
   int fail_count = 0, comparisons = 0, pulses = 0;
   // Open drain wire with pull-up
   assign sda_line = ~(sda_low | ~sda_oe_n);
   redriver_config_register_bank #(.REVISION_CODE(REV), .PART_CODE_LOW(PLO),
      .PART_CODE_MID(PMI), .PART_CODE_HIGH(PHI)) u_redriver_config_register_bank (
      .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .target_addr_sel(sel), .supply_high_valid(sup_hi),
      .supply_low_valid(sup_lo), .speed_of_operation(spd), .repeater_status(rep),
      .link_status(lnk), .repeater_enable(repeater_enable), .soft_reset_pulse(soft_reset_pulse),
      .auto_speed(auto_speed), .low_full_speed(low_full_speed), .link_speed_role_opmode(lsro),
      .forced_single_ended_one(forced_single_ended_one), .embedded_rx_tuning(erx),
      .embedded_tx_tuning(etx), .legacy_rx_tuning(lrx), .legacy_tx_emphasis(ltxe),
      .legacy_tx_edge_swing(ltxs), .legacy_hs_termination(lterm),
      .legacy_disconnect_level(ldisc), .remote_access_key(rkey),
      .control_message_gate_enable(control_message_gate_enable));
   i2c_ctrl_model u_i2c_ctrl_model (.clk(clk), .sda_line(sda_line), .scl(scl),
      .sda_low(sda_low));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (soft_reset_pulse === 1'b1) pulses <= pulses + 1;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic open_at(input logic [7:0] off);
      logic a;
      u_i2c_ctrl_model.start_c();
      u_i2c_ctrl_model.wbyte(dev_w, a);
      chk({7'h0, a}, 8'h00);
      u_i2c_ctrl_model.wbyte(off, a);
      chk({7'h0, a}, 8'h00);
   endtask
   task automatic wr(input logic [7:0] off, input int n);
      logic a;
      open_at(off);
      for (int i = 0; i < n; i++) begin
         u_i2c_ctrl_model.wbyte(buf_q[i], a);
         chk({7'h0, a}, 8'h00);
      end
      u_i2c_ctrl_model.stop_c();
   endtask
   task automatic rd(input logic [7:0] off, input int n);
      logic a;
      open_at(off);
      u_i2c_ctrl_model.start_c();
      u_i2c_ctrl_model.wbyte(dev_w | 8'h01, a);
      chk({7'h0, a}, 8'h00);
      for (int i = 0; i < n; i++) u_i2c_ctrl_model.rbyte(i == n - 1, buf_q[i]);
      u_i2c_ctrl_model.stop_c();
   endtask
   function automatic logic [7:0] dflt(input logic [7:0] a);
      case (a)
         8'h04: return 8'h20;
         8'h05: return 8'h10;
         8'h06: return 8'h50;
         8'h08: return 8'h62;
         8'h09: return 8'h02;
         8'h0c: return 8'hff;
         8'h0f: return {4'h0, spd, rep};
         8'h10: return {5'h0, lnk};
         8'h13: return REV;
         8'h14: return PLO;
         8'h15: return PMI;
         8'h16: return PHI;
         default: return (a > 8'h16) ? 8'hff : 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] pat(input logic [7:0] o);
      return {o[3:0], ~o[3:0]};
   endfunction
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic a;
      logic [7:0] o, e;
      rst = 1'b1;
      sup_hi = 1'b1;
      sup_lo = 1'b1;
      sel = 2'b10;
      spd = 2'b10;
      rep = 2'b01;
      lnk = 3'b101;
      dev_w = 8'h96;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      rd(8'h00, 24);
      for (int i = 0; i < 24; i++) chk(buf_q[i], dflt(8'(i)));
      chk({6'h0, repeater_enable, auto_speed}, 8'h03);
      $display("test defaults done");
      for (int i = 0; i < 13; i++) buf_q[i] = pat(8'(i + 2));
      wr(8'h02, 13);
      rd(8'h02, 13);
      for (int i = 0; i < 13; i++) begin
         o = 8'(i + 2);
         e = (o == 8'h03 || o == 8'h0e) ? (pat(o) & 8'h01) : (o == 8'h0b) ? 8'h00 : dflt(o);
         if (o != 8'h03 && o != 8'h0e && o != 8'h0b && o != 8'h0c) e = pat(o);
         chk(buf_q[i], e);
      end
      chk(ltxe, pat(8'h07));
      chk(ldisc, pat(8'h0a));
      chk({6'h0, forced_single_ended_one, control_message_gate_enable}, 8'h01);
      for (int c = 0; c < 4; c++) begin
         buf_q[0] = {2'(c), 6'h00};
         wr(8'h02, 1);
         chk({6'h0, low_full_speed, auto_speed}, c == 0 ? 8'h01 : c == 1 ? 8'h02 : 8'h00);
      end
      $display("test read write done");
      lnk <= 3'b010;
      for (int i = 0; i < 8; i++) buf_q[i] = 8'hff;
      wr(8'h0f, 8);
      rd(8'h0f, 8);
      for (int i = 0; i < 8; i++) chk(buf_q[i], dflt(8'(i + 15)));
      $display("test read only done");
      buf_q[0] = 8'h77;
      buf_q[1] = 8'h77;
      buf_q[2] = 8'h00;
      buf_q[3] = 8'h3c;
      wr(8'hff, 4);
      rd(8'hfe, 5);
      for (int i = 0; i < 5; i++) chk(buf_q[i], wexp[i]);
      chk(8'(pulses), 8'h00);
      $display("test wrap done");
      buf_q[0] = 8'h01;
      wr(8'h01, 1);
      rd(8'h01, 4);
      for (int i = 0; i < 4; i++) chk(buf_q[i], dflt(8'(i + 1)));
      chk(8'(pulses), 8'h01);
      $display("test soft reset done");
      u_i2c_ctrl_model.start_c();
      u_i2c_ctrl_model.wbyte(8'h8e, a);
      chk({7'h0, a}, 8'h01);
      u_i2c_ctrl_model.stop_c();
      sel <= 2'b01;
      dev_w = 8'h8e;
      buf_q[0] = 8'h77;
      wr(8'h05, 1);
      sup_lo <= 1'b0;
      repeat (6) @(posedge clk);
      chk({7'h0, repeater_enable}, 8'h00);
      u_i2c_ctrl_model.start_c();
      u_i2c_ctrl_model.wbyte(dev_w, a);
      chk({7'h0, a}, 8'h01);
      u_i2c_ctrl_model.stop_c();
      sup_lo <= 1'b1;
      repeat (3) @(posedge clk);
      rd(8'h05, 1);
      chk(buf_q[0], 8'h10);
      $display("test supplies done");
      test_done();
   end
endmodule // redriver_config_register_bank_tb_top

// ==== redriver_consts.vh ====
`ifndef REDRIVER_CONSTS_VH
`define REDRIVER_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_RESERVED_ZERO 8'h00
`define OFS_SOFTWARE_RESET 8'h01
`define OFS_LINK_SPEED_ROLE 8'h02
`define OFS_LINK_FORCE 8'h03
`define OFS_EMBEDDED_RX 8'h04
`define OFS_EMBEDDED_TX 8'h05
`define OFS_LEGACY_RX 8'h06
`define OFS_LEGACY_TX_EMPH 8'h07
`define OFS_LEGACY_TX_EDGE 8'h08
`define OFS_LEGACY_HS_TERM 8'h09
`define OFS_LEGACY_DISC 8'h0a
`define OFS_RESERVED_RO 8'h0b
`define OFS_REMOTE_KEY 8'h0d
`define OFS_CTRL_MSG_GATE 8'h0e
`define OFS_SPEED_STATE 8'h0f
`define OFS_CONN_STATE 8'h10
`define OFS_RAZ_FIRST 8'h11
`define OFS_RAZ_LAST 8'h12
`define OFS_REVISION 8'h13
`define OFS_PART_LOW 8'h14
`define OFS_PART_MID 8'h15
`define OFS_PART_HIGH 8'h16

// ----------------------------------------
// Power-on values
// ----------------------------------------
`define RST_ZERO 8'h00
`define RST_EMBEDDED_RX 8'h20
`define RST_EMBEDDED_TX 8'h10
`define RST_LEGACY_RX 8'h50
`define RST_LEGACY_TX_EDGE 8'h62
`define RST_LEGACY_HS_TERM 8'h02

// ----------------------------------------
// Write masks and field positions
// ----------------------------------------
`define WMASK_FULL 8'hff
`define WMASK_BIT0 8'h01
`define WMASK_NONE 8'h00
`define W1S_NONE 8'h00
`define SOFT_RESET_BIT 0
`define SPEED_MSB 7
`define SPEED_LSB 6
`define SPEED_AUTO 2'b00
`define SPEED_LOW_FULL 2'b01
`define GATE_ENABLE_BIT 0
`define UNMAPPED_READ 8'hff
`define TARGET_ADDR_HIGH 3'b100
`define TARGET_ADDR_LOW 2'b11
`define SLOT_COUNT 16

`endif
